//--- spd_regs.svh
// Register offsets, status bit positions and counts for the serial transfer block
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH
`define SPD_PORT_BIT 14
`define SPD_OFF_IER 14'h0008
`define SPD_OFF_IDR 14'h000c
`define SPD_OFF_IMR 14'h0010
`define SPD_OFF_STAT 14'h0014
`define SPD_OFF_RX_PTR 14'h0030
`define SPD_OFF_RX_CNT 14'h0034
`define SPD_OFF_TX_PTR 14'h0038
`define SPD_OFF_TX_CNT 14'h003c
`define SPD_ST_RX_READY 0
`define SPD_ST_TX_READY 1
`define SPD_ST_END_RX 3
`define SPD_ST_END_TX 4
`define SPD_IRQ_W 5
`define SPD_MASK_RESET 5'h00
`define SPD_PTR_RESET 32'h0000_0000
`define SPD_CNT_RESET 16'h0000
`define SPD_XFER_SIZE 1
`define SPD_NUM_PORTS 2
`endif

//--- spd_pkg.sv
// Types shared by the serial transfer block
package spd_pkg;
  typedef logic [31:0] spd_word_type;
  typedef logic [15:0] spd_count_type;
  typedef logic [7:0] spd_byte_type;
  typedef enum logic [2:0] {
    SPD_CH_IDLE = 3'b001,
    SPD_CH_BUSY = 3'b010,
    SPD_CH_LOAD = 3'b100
  } spd_ch_state_type;
endpackage

//--- spd_chan_if.sv
// Register link between the top and one transfer channel
`timescale 1ns/1ns
interface spd_chan_if;
  logic ptr_we;
  logic cnt_we;
  logic [31:0] wdata;
  logic [31:0] ptr;
  logic [15:0] cnt;
  modport top (output ptr_we, output cnt_we, output wdata, input ptr, input cnt);
  modport chan (input ptr_we, input cnt_we, input wdata, output ptr, output cnt);
endinterface

//--- spd_chan.sv
// One transfer channel: moves bytes between a serial port and memory
`timescale 1ns/1ns
`include "spd_regs.svh"
module spd_chan #(
  parameter bit IS_TX = 1'b0,
  parameter int unsigned XFER_SIZE = `SPD_XFER_SIZE
) (
  input wire logic clk,
  input wire logic rst_b,
  spd_chan_if.chan regs,
  input wire logic ser_ready,
  input wire spd_pkg::spd_byte_type ser_rdata,
  output logic ser_strobe,
  output spd_pkg::spd_byte_type ser_wdata,
  output logic mem_req,
  output logic mem_write,
  output spd_pkg::spd_word_type mem_addr,
  output spd_pkg::spd_byte_type mem_wdata,
  input wire logic mem_ack,
  input wire spd_pkg::spd_byte_type mem_rdata
);
  import spd_pkg::*;
  spd_ch_state_type state_reg;
  spd_ch_state_type state_next;
  spd_word_type ptr_reg;
  spd_count_type cnt_reg;
  spd_byte_type data_reg;
  logic start;
  logic done;

  // idle channel with zero count starts nothing
  assign start = (state_reg == SPD_CH_IDLE) && ser_ready && (cnt_reg != 16'h0000);
  assign done = (state_reg == SPD_CH_BUSY) && mem_ack;
  assign mem_req = (state_reg == SPD_CH_BUSY);
  assign mem_write = ~IS_TX;
  assign mem_addr = ptr_reg;
  assign mem_wdata = data_reg;
  assign ser_wdata = data_reg;
  assign ser_strobe = IS_TX ? (state_reg == SPD_CH_LOAD) : start;
  assign regs.ptr = ptr_reg;
  assign regs.cnt = cnt_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SPD_CH_IDLE: begin
        if (start) begin
          state_next = SPD_CH_BUSY;
        end
      end
      SPD_CH_BUSY: begin
        if (done) begin
          state_next = IS_TX ? SPD_CH_LOAD : SPD_CH_IDLE;
        end
      end
      SPD_CH_LOAD: begin
        state_next = SPD_CH_IDLE;
      end
      default: begin
        state_next = SPD_CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= SPD_CH_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Receive byte taken at start, transmit byte at memory answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_reg <= 8'h00;
    end else if (!IS_TX && start) begin
      data_reg <= ser_rdata;
    end else if (IS_TX && done) begin
      data_reg <= mem_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_reg <= `SPD_PTR_RESET;
    end else if (regs.ptr_we) begin
      ptr_reg <= regs.wdata;
    end else if (done) begin
      ptr_reg <= ptr_reg + 32'(XFER_SIZE);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= `SPD_CNT_RESET;
    end else if (regs.cnt_we) begin
      cnt_reg <= regs.wdata[15:0];
    end else if (done) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // completed transfer steps pointer and count
  a_step_advance: assert property (@(posedge clk) disable iff (!rst_b)
    done && !regs.ptr_we && !regs.cnt_we |=>
      ptr_reg == $past(ptr_reg) + 32'(XFER_SIZE) && cnt_reg == $past(cnt_reg) - 16'h0001)
    else $error("channel did not advance after transfer");
  a_zero_halt: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == SPD_CH_IDLE && cnt_reg == 16'h0000 |=> !mem_req)
    else $error("channel started with zero count");
endmodule

//--- spd_top.sv
// Transfer channels and interrupt masking for two serial ports
// How it works
// - Each port's interrupt line is the OR over bits of status AND mask.
// - Mask reads back in its own register, set by enable writes, cleared by disable writes.
// - A zero bit in an enable or disable write leaves that mask bit alone.
// - Four channels, one receive and one transmit for each of the two ports.
// - Each channel has a 32-bit pointer and 16-bit count in its port's register space.
// - A channel whose count has run out shows an end flag in its port's status.
// - Registers are word access only; low address bits are ignored.
`timescale 1ns/1ns
`include "spd_regs.svh"
module spd_top #(
  parameter int unsigned XFER_SIZE = `SPD_XFER_SIZE
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [14:0] reg_addr,
  input wire spd_pkg::spd_word_type reg_wdata,
  output spd_pkg::spd_word_type reg_rdata,
  input wire logic [1:0] ser_rx_ready,
  input wire spd_pkg::spd_byte_type ser_rx_data [2],
  output logic [1:0] ser_rx_take,
  input wire logic [1:0] ser_tx_ready,
  output spd_pkg::spd_byte_type ser_tx_data [2],
  output logic [1:0] ser_tx_load,
  output logic [3:0] mem_req,
  output logic [3:0] mem_write,
  output spd_pkg::spd_word_type mem_addr [4],
  output spd_pkg::spd_byte_type mem_wdata [4],
  input wire logic [3:0] mem_ack,
  input wire spd_pkg::spd_byte_type mem_rdata [4],
  output logic [1:0] irq_out
);
  import spd_pkg::*;

  localparam int NP = `SPD_NUM_PORTS;
  localparam int IW = `SPD_IRQ_W;

  function automatic logic [13:0] word_off(input logic [14:0] a);
    word_off = {a[13:2], 2'b00};
  endfunction

  function automatic logic hit(input logic [14:0] a, input logic p, input logic [13:0] off);
    hit = (a[`SPD_PORT_BIT] == p) && (word_off(a) == off);
  endfunction

  spd_chan_if ch_if [4] ();
  spd_word_type ptr_arr [4];
  spd_count_type cnt_arr [4];
  logic [IW-1:0] imr_reg [NP];
  logic [IW-1:0] stat [NP];
  spd_word_type rdata_reg;
  spd_word_type rd_next;
  logic [13:0] rd_off;
  logic rd_port;

  assign reg_rdata = rdata_reg;

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      spd_chan #(.IS_TX(1'b0), .XFER_SIZE(XFER_SIZE)) u_rx (
        .clk(clk),
        .rst_b(rst_b),
        .regs(ch_if[2*p]),
        .ser_ready(ser_rx_ready[p]),
        .ser_rdata(ser_rx_data[p]),
        .ser_strobe(ser_rx_take[p]),
        .ser_wdata(),
        .mem_req(mem_req[2*p]),
        .mem_write(mem_write[2*p]),
        .mem_addr(mem_addr[2*p]),
        .mem_wdata(mem_wdata[2*p]),
        .mem_ack(mem_ack[2*p]),
        .mem_rdata(mem_rdata[2*p])
      );
      spd_chan #(.IS_TX(1'b1), .XFER_SIZE(XFER_SIZE)) u_tx (
        .clk(clk),
        .rst_b(rst_b),
        .regs(ch_if[2*p+1]),
        .ser_ready(ser_tx_ready[p]),
        .ser_rdata(8'h00),
        .ser_strobe(ser_tx_load[p]),
        .ser_wdata(ser_tx_data[p]),
        .mem_req(mem_req[2*p+1]),
        .mem_write(mem_write[2*p+1]),
        .mem_addr(mem_addr[2*p+1]),
        .mem_wdata(mem_wdata[2*p+1]),
        .mem_ack(mem_ack[2*p+1]),
        .mem_rdata(mem_rdata[2*p+1])
      );

      // pointer and count strobes in this port's space
      assign ch_if[2*p].ptr_we = reg_wr && hit(reg_addr, 1'(p), `SPD_OFF_RX_PTR);
      assign ch_if[2*p].cnt_we = reg_wr && hit(reg_addr, 1'(p), `SPD_OFF_RX_CNT);
      assign ch_if[2*p].wdata = reg_wdata;
      assign ch_if[2*p+1].ptr_we = reg_wr && hit(reg_addr, 1'(p), `SPD_OFF_TX_PTR);
      assign ch_if[2*p+1].cnt_we = reg_wr && hit(reg_addr, 1'(p), `SPD_OFF_TX_CNT);
      assign ch_if[2*p+1].wdata = reg_wdata;
      assign ptr_arr[2*p] = ch_if[2*p].ptr;
      assign cnt_arr[2*p] = ch_if[2*p].cnt;
      assign ptr_arr[2*p+1] = ch_if[2*p+1].ptr;
      assign cnt_arr[2*p+1] = ch_if[2*p+1].cnt;

      always_comb begin
        stat[p] = '0;
        stat[p][`SPD_ST_RX_READY] = ser_rx_ready[p];
        stat[p][`SPD_ST_TX_READY] = ser_tx_ready[p];
        stat[p][`SPD_ST_END_RX] = (cnt_arr[2*p] == 16'h0000);
        stat[p][`SPD_ST_END_TX] = (cnt_arr[2*p+1] == 16'h0000);
      end

      // zero bits keep their mask value
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          imr_reg[p] <= `SPD_MASK_RESET;
        end else if (reg_wr && hit(reg_addr, 1'(p), `SPD_OFF_IER)) begin
          imr_reg[p] <= imr_reg[p] | reg_wdata[IW-1:0];
        end else if (reg_wr && hit(reg_addr, 1'(p), `SPD_OFF_IDR)) begin
          imr_reg[p] <= imr_reg[p] & ~reg_wdata[IW-1:0];
        end
      end

      // masked status ORed onto the line
      assign irq_out[p] = |(stat[p] & imr_reg[p]);

      // line from raw sources and mask
      a_irq_combine: assert property (@(posedge clk) disable iff (!rst_b)
        irq_out[p] == ((ser_rx_ready[p] && imr_reg[p][`SPD_ST_RX_READY])
          || (ser_tx_ready[p] && imr_reg[p][`SPD_ST_TX_READY])
          || (cnt_arr[2*p] == 16'h0000 && imr_reg[p][`SPD_ST_END_RX])
          || (cnt_arr[2*p+1] == 16'h0000 && imr_reg[p][`SPD_ST_END_TX])))
        else $error("interrupt line disagrees with status and mask");
      a_mask_set: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && hit(reg_addr, 1'(p), `SPD_OFF_IER) |=>
          (imr_reg[p] & $past(reg_wdata[IW-1:0])) == $past(reg_wdata[IW-1:0]))
        else $error("enable write did not set mask");
      a_mask_clear: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && hit(reg_addr, 1'(p), `SPD_OFF_IDR) |=>
          (imr_reg[p] & $past(reg_wdata[IW-1:0])) == '0)
        else $error("disable write did not clear mask");
      a_mask_keep: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && (hit(reg_addr, 1'(p), `SPD_OFF_IER) || hit(reg_addr, 1'(p), `SPD_OFF_IDR))
          |=> (imr_reg[p] & ~$past(reg_wdata[IW-1:0]))
            == ($past(imr_reg[p]) & ~$past(reg_wdata[IW-1:0])))
        else $error("zero bit changed mask");
      a_end_flag: assert property (@(posedge clk) disable iff (!rst_b)
        ch_if[2*p].cnt_we && reg_wdata[15:0] == 16'h0000 |=> stat[p][`SPD_ST_END_RX])
        else $error("end of receive not flagged");
      // receive take then own write request
      sequence s_rx_accept;
        ser_rx_ready[p] ##1 (mem_req[2*p] && mem_write[2*p]);
      endsequence
      a_rx_owner: assert property (@(posedge clk) disable iff (!rst_b)
        ser_rx_take[p] |-> s_rx_accept)
        else $error("receive take without own channel request");
      // memory answer then one load pulse
      sequence s_tx_answer;
        mem_req[2*p+1] && mem_ack[2*p+1];
      endsequence
      sequence s_tx_load_once;
        ser_tx_load[p] ##1 !ser_tx_load[p];
      endsequence
      a_tx_load_next: assert property (@(posedge clk) disable iff (!rst_b)
        s_tx_answer |=> s_tx_load_once)
        else $error("transmit byte not loaded once after memory answer");
      // last receive step raises end flag
      sequence s_rx_last;
        mem_req[2*p] && mem_ack[2*p] && cnt_arr[2*p] == 16'h0001 && !ch_if[2*p].cnt_we;
      endsequence
      a_end_rx_set: assert property (@(posedge clk) disable iff (!rst_b)
        s_rx_last |=> stat[p][`SPD_ST_END_RX])
        else $error("end of receive missing after last step");
      // last transmit step raises end flag
      sequence s_tx_last;
        mem_req[2*p+1] && mem_ack[2*p+1] && cnt_arr[2*p+1] == 16'h0001
          && !ch_if[2*p+1].cnt_we;
      endsequence
      a_end_tx_set: assert property (@(posedge clk) disable iff (!rst_b)
        s_tx_last |=> stat[p][`SPD_ST_END_TX])
        else $error("end of transmit missing after last step");
    end
  endgenerate

  assign rd_off = word_off(reg_addr);
  assign rd_port = reg_addr[`SPD_PORT_BIT];

  // read decode on word offset; unmapped reads zero
  always_comb begin
    rd_next = '0;
    unique case (rd_off)
      `SPD_OFF_IMR: rd_next = {{(32-IW){1'b0}}, imr_reg[rd_port]};
      `SPD_OFF_STAT: rd_next = {{(32-IW){1'b0}}, stat[rd_port]};
      `SPD_OFF_RX_PTR: rd_next = ptr_arr[{rd_port, 1'b0}];
      `SPD_OFF_RX_CNT: rd_next = {16'h0000, cnt_arr[{rd_port, 1'b0}]};
      `SPD_OFF_TX_PTR: rd_next = ptr_arr[{rd_port, 1'b1}];
      `SPD_OFF_TX_CNT: rd_next = {16'h0000, cnt_arr[{rd_port, 1'b1}]};
      default: rd_next = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      rdata_reg <= rd_next;
    end
  end

  // count write lands in the count register
  a_cnt_load: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && hit(reg_addr, 1'b0, `SPD_OFF_TX_CNT) |=> cnt_arr[1] == $past(reg_wdata[15:0]))
    else $error("count write lost");
  // unaligned mask read answers the word
  a_word_read: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && word_off(reg_addr) == `SPD_OFF_IMR |=>
      reg_rdata == {{(32-IW){1'b0}}, $past(imr_reg[reg_addr[`SPD_PORT_BIT]])})
    else $error("mask read returned wrong word");
endmodule

//--- spd_far_model.sv
// Serial ports and memory as seen by the transfer channels
`timescale 1ns/1ns
module spd_far_model (
  input wire logic clk,
  input wire logic en,
  input wire logic slow,
  input wire logic [1:0] ser_rx_take,
  input wire logic [1:0] ser_tx_load,
  input wire spd_pkg::spd_byte_type ser_tx_data [2],
  input wire logic [3:0] mem_req,
  input wire spd_pkg::spd_word_type mem_addr [4],
  input wire spd_pkg::spd_byte_type mem_wdata [4],
  output logic [1:0] ser_rx_ready,
  output spd_pkg::spd_byte_type ser_rx_data [2],
  output logic [1:0] ser_tx_ready,
  output logic [3:0] mem_ack,
  output spd_pkg::spd_byte_type mem_rdata [4],
  output logic [15:0] rx_n [2],
  output logic [15:0] tx_n [2],
  output spd_pkg::spd_byte_type last_wr [2],
  output spd_pkg::spd_byte_type last_tx [2]
);
  import spd_pkg::*;
  logic [1:0] took;
  logic [1:0] loaded;
  initial begin
    ser_rx_ready = 2'h0;
    ser_tx_ready = 2'h0;
    mem_ack = 4'h0;
    took = 2'h0;
    loaded = 2'h0;
    rx_n = '{16'h0000, 16'h0000};
    tx_n = '{16'h0000, 16'h0000};
  end
  always @(posedge clk) begin
    took <= ser_rx_take & ser_rx_ready;
    loaded <= ser_tx_load;
    for (int p = 0; p < 2; p++) begin
      if (ser_rx_take[p] && ser_rx_ready[p]) rx_n[p] <= rx_n[p] + 16'h0001;
      if (ser_tx_load[p]) begin
        tx_n[p] <= tx_n[p] + 16'h0001;
        last_tx[p] <= ser_tx_data[p];
      end
      if (mem_ack[2*p] && mem_req[2*p]) last_wr[p] <= mem_wdata[2*p];
    end
  end
  // Ready drops after each accepted byte; slow memory answers late
  always @(negedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (!en || took[p]) ser_rx_ready[p] <= 1'b0;
      else if ($urandom_range(1) == 0) ser_rx_ready[p] <= 1'b1;
      ser_tx_ready[p] <= en && !loaded[p];
    end
    for (int i = 0; i < 4; i++) begin
      mem_ack[i] <= mem_req[i] && !mem_ack[i] && (!slow || $urandom_range(2) == 0);
    end
  end
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      ser_rx_data[p] = ser_rx_ready[p] ? rx_n[p][7:0] + {p[0], 7'h00} : ~rx_n[p][7:0];
    end
    for (int i = 0; i < 4; i++) begin
      mem_rdata[i] = (mem_addr[i][7:0] ^ 8'h5a) ^ {8{!mem_ack[i]}};
    end
  end
endmodule

//--- test_serial_peripheral_dma_and_irq_mask.sv
// Self-checking bench for the serial transfer block
`timescale 1ns/1ns
`include "spd_regs.svh"
module test_serial_peripheral_dma_and_irq_mask;
  import spd_pkg::*;
  localparam int unsigned XS = 1;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [14:0] reg_addr = 15'h0000;
  spd_word_type reg_wdata = 32'h0000_0000;
  spd_word_type reg_rdata;
  logic [1:0] ser_rx_ready, ser_rx_take, ser_tx_ready, ser_tx_load, irq_out;
  spd_byte_type ser_rx_data [2], ser_tx_data [2], last_wr [2], last_tx [2];
  spd_byte_type mem_wdata [4], mem_rdata [4];
  logic [3:0] mem_req, mem_write, mem_ack;
  spd_word_type mem_addr [4];
  logic [15:0] rx_n [2], tx_n [2];
  logic en = 1'b0;
  logic slow = 1'b0;
  int miscompares = 0;
  int compares = 0;
  logic [4:0] mask [2];
  logic [31:0] d, rp, tp;
  logic [15:0] rc, tc;
  logic [13:0] offs [4] = '{`SPD_OFF_RX_PTR, `SPD_OFF_RX_CNT, `SPD_OFF_TX_PTR, `SPD_OFF_TX_CNT};
  always #2 clk = ~clk;
  spd_top #(.XFER_SIZE(XS)) DUT (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ser_rx_ready(ser_rx_ready), .ser_rx_data(ser_rx_data), .ser_rx_take(ser_rx_take),
    .ser_tx_ready(ser_tx_ready), .ser_tx_data(ser_tx_data), .ser_tx_load(ser_tx_load),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq_out(irq_out));
  spd_far_model far (.clk(clk), .en(en), .slow(slow), .ser_rx_take(ser_rx_take),
    .ser_tx_load(ser_tx_load), .ser_tx_data(ser_tx_data), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .ser_rx_ready(ser_rx_ready),
    .ser_rx_data(ser_rx_data), .ser_tx_ready(ser_tx_ready), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .rx_n(rx_n), .tx_n(tx_n), .last_wr(last_wr), .last_tx(last_tx));
  function automatic logic [31:0] irq_exp(logic [4:0] st, logic [4:0] m);
    return {31'h0, |(st & m)};
  endfunction
  // Random low address bits must not matter
  task automatic wr(input logic p, input logic [13:0] off, input spd_word_type v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = {p, off | 14'($urandom_range(3))};
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rchk(input string name, input logic p, input logic [13:0] off,
    input logic [31:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = {p, off | 14'($urandom_range(3))};
    @(negedge clk);
    reg_rd = 1'b0;
    chk(name, exp, reg_rdata);
  endtask
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'he99188d9));
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    for (int p = 0; p < 2; p++) begin
      mask[p] = 5'h00;
      rchk("imr", p, `SPD_OFF_IMR, 32'h0);
      rchk("stat", p, `SPD_OFF_STAT, 32'h18);
      for (int k = 0; k < 4; k++) rchk("chan_reg", p, offs[k], 32'h0);
      rchk("unmapped", p, 14'h0040, 32'h0);
    end
    $display("test reset done");
    for (int i = 0; i < 30; i++) begin
      d = (i < 2) ? 32'hffff_ffff : $urandom;
      if (i != 1 && $urandom_range(1)) begin
        wr(i[0], `SPD_OFF_IER, d);
        mask[i[0]] |= d[4:0];
      end else begin
        wr(i[0], `SPD_OFF_IDR, d);
        mask[i[0]] &= ~d[4:0];
      end
      rchk("imr", i[0], `SPD_OFF_IMR, {27'h0, mask[i[0]]});
      for (int p = 0; p < 2; p++) chk("irq", irq_exp(5'h18, mask[p]), {31'h0, irq_out[p]});
    end
    $display("test mask done");
    en = 1'b1;
    repeat (20) @(negedge clk);
    chk("idle_rx", 32'h0, {16'h0, rx_n[0]});
    chk("mem_write", 32'h5, {28'h0, mem_write});
    for (int p = 0; p < 2; p++) begin
      en = 1'b0;
      slow = p[0];
      rp = $urandom;
      tp = $urandom;
      rc = p ? 16'h0001 : 16'($urandom_range(8, 2));
      tc = 16'($urandom_range(8, 1));
      wr(p, `SPD_OFF_RX_PTR, rp);
      wr(p, `SPD_OFF_RX_CNT, {16'h0, rc});
      wr(p, `SPD_OFF_TX_PTR, tp);
      wr(p, `SPD_OFF_TX_CNT, {16'h0, tc});
      wr(p, `SPD_OFF_IDR, 32'h1f);
      wr(p, `SPD_OFF_IER, 32'h18);
      rchk("rx_cnt", p, `SPD_OFF_RX_CNT, {16'h0, rc});
      chk("irq_busy", 32'h0, {31'h0, irq_out[p]});
      en = 1'b1;
      for (int n = 0; n < 500 && !(rx_n[p] == rc && tx_n[p] == tc); n++) @(negedge clk);
      repeat (40) @(negedge clk);
      chk("rx_n", {16'h0, rc}, {16'h0, rx_n[p]});
      chk("tx_n", {16'h0, tc}, {16'h0, tx_n[p]});
      chk("rx_byte", {24'h0, rc[7:0] - 8'h01 + {p[0], 7'h00}}, {24'h0, last_wr[p]});
      chk("tx_byte", {24'h0, 8'(tp + (tc - 1) * XS) ^ 8'h5a}, {24'h0, last_tx[p]});
      rchk("rx_ptr", p, `SPD_OFF_RX_PTR, rp + rc * XS);
      rchk("tx_ptr", p, `SPD_OFF_TX_PTR, tp + tc * XS);
      rchk("tx_cnt", p, `SPD_OFF_TX_CNT, 32'h0);
      chk("irq_end", 32'h1, {31'h0, irq_out[p]});
    end
    $display("test transfer done");
    end_of_test();
  end
endmodule
